// ==== verilog/hfm_defs.svh ====
// hfm_defs.svh: bit positions, reset values and timing counts for the
// heater / sensor fault monitor.
// assumes: included by the package and by both design modules.
//
// How it works
// - ref pin check needs enable, no impedance test
// - ref low must persist filter count cycles
// - validated ref short latches flag until clear
// - sense inside window, filtered, flags short
// - sense short only sets its latched flag
// - filter counters zero on condition loss, reset
// - gate on and drain high flags battery short
// - two-bit field picks battery filter count
// - battery short latches gate off, sets flag
// - gate off and drain low flags ground short
// - ground short: flag, gate off, open test
// - open test: sink off, source on, compare
// - open result sets open flag, clears ground
// - normally sink on and source off
// - clear command wipes faults, then self-clears
// - confirm bits must be zero and one
// - serial fault: drop frame, flags, select zero
// - frame length must be 64 plus 8n
// - pump source with pulldowns is invalid
// - locked pump settings changed while enabled invalid
// - select bit picks status or input echo
// - status reloaded while chip select inactive
`ifndef HFM_DEFS_SVH
`define HFM_DEFS_SVH
// -----------------------------------------------------------------
// input frame fields
// -----------------------------------------------------------------
`define HFM_B_REG 59
`define HFM_B_REFPD 58
`define HFM_B_REFDIAG 57
`define HFM_B_PUMPEN 54
`define HFM_B_PCHAN 53
`define HFM_B_PUMPPD 52
`define HFM_B_COMP 51
`define HFM_B_CLAMPEN 50
`define HFM_B_CLAMPLV 49
`define HFM_B_CLAMP_SIM_SELECT 48
`define HFM_B_CLEAR 47
`define HFM_B_CAP_HI 39
`define HFM_B_CAP_LO 34
`define HFM_B_BATTTH 31
`define HFM_B_CBHI 15
`define HFM_B_CBLO 14
`define HFM_B_FT_HI 12
`define HFM_B_FT_LO 11
`define HFM_CFG_RST 64'h0000_0000_0000_0000
// -----------------------------------------------------------------
// status word and frame shape
// -----------------------------------------------------------------
`define HFM_F_REF 0
`define HFM_F_SNS 1
`define HFM_F_BATT 2
`define HFM_F_HGND 3
`define HFM_F_OPEN 4
`define HFM_F_SPIA 5
`define HFM_F_SPIB 6
`define HFM_NFLAG 7
`define HFM_FRAME_MIN 64
`define HFM_LEN_W 10
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define HFM_CW 12
`define HFM_CLK_NS 50
`define HFM_FILT_REF 16
`define HFM_FILT_SNS 16
`define HFM_FILT_HGND 16
`define HFM_FILT_BATT0 8
`define HFM_FILT_BATT1 16
`define HFM_FILT_BATT2 32
`define HFM_FILT_BATT3 64
`define HFM_OC_SETTLE_NS 10000
`define HFM_OC_SETTLE_CYC \
  ((`HFM_OC_SETTLE_NS + `HFM_CLK_NS - 1) / `HFM_CLK_NS)
`endif

// ==== verilog/hfm_pkg.sv ====
// hfm_pkg.sv: state types of the fault monitor.
// assumes: hfm_defs.svh on the include path.
`include "hfm_defs.svh"
package hfm_pkg;
  typedef enum logic [1:0] {OC_IDLE, OC_SINK_OFF, OC_SRC_ON, OC_HOLD}
    hfm_oc_e;
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic csn_d;
    logic so_oe;
    logic [2:0] frm_tog;
    logic [63:0] cfg;
    logic [63:0] status;
    logic [3:0][`HFM_CW-1:0] cnt;
    logic [`HFM_NFLAG-1:0] flags;
    logic gate_lock;
    logic gate;
    logic sink;
    logic src;
    hfm_oc_e oc;
    logic [`HFM_CW-1:0] oc_wait;
  } hfm_sys_s;
  typedef struct packed {
    logic [63:0] rx;
    logic [63:0] tx;
    logic [`HFM_LEN_W-1:0] cnt;
    logic ge64;
    logic so;
    logic frm_tog;
  } hfm_link_s;
endpackage : hfm_pkg

// ==== verilog/hfm_spi_link.sv ====
// hfm_spi_link.sv: serial shift logic on the serial clock.
// assumes: serial clock only toggles while chip select is low; the
// status word is held stable by the system side during a frame.
`timescale 1ns/1ps
`include "hfm_defs.svh"
module hfm_spi_link
  import hfm_pkg::*;
(
  // clock and reset
  input wire logic i_spi_clk,
  input wire logic i_rstn,
  // pins
  input wire logic i_csn,
  input wire logic i_si,
  output logic o_so,
  // system side
  input wire logic [63:0] i_status_word,
  output logic [63:0] o_rx_word,
  output logic [`HFM_LEN_W-1:0] o_bit_cnt,
  output logic o_ge64,
  output logic o_frame_seen
);
  hfm_link_s st;
  hfm_link_s next_st;
  logic first;

  // -----------------------------------------------------------------
  // frame start marker
  // -----------------------------------------------------------------
  // set by chip select itself, since the clock is idle between frames
  always_ff @(posedge i_spi_clk or posedge i_csn or negedge i_rstn) begin
    if (!i_rstn) begin
      first <= 1'b1;
    end else if (i_csn) begin
      first <= 1'b1;
    end else begin
      first <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // shifting
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // rx keeps the last 64 bits so daisy chained frames work
    next_st.rx = {st.rx[62:0], i_si};
    if (first) begin
      // one toggle per frame that saw a clock edge
      next_st.frm_tog = ~st.frm_tog;
      next_st.cnt = `HFM_LEN_W'(1);
      next_st.ge64 = 1'b0;
      next_st.so = i_status_word[63];
      next_st.tx = {i_status_word[62:0], i_si};
    end else begin
      next_st.cnt = st.cnt + `HFM_LEN_W'(1);
      if (st.cnt == `HFM_LEN_W'(`HFM_FRAME_MIN - 1)) begin
        next_st.ge64 = 1'b1;
      end
      next_st.so = st.tx[63];
      next_st.tx = {st.tx[62:0], i_si};
    end
  end

  always_ff @(posedge i_spi_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_so = st.so;
  assign o_rx_word = st.rx;
  assign o_bit_cnt = st.cnt;
  assign o_ge64 = st.ge64;
  // level toggle, still valid after chip select rises again
  assign o_frame_seen = st.frm_tog;
endmodule : hfm_spi_link

// ==== verilog/hfm_fault_monitor.sv ====
// hfm_fault_monitor.sv: top of the heater and sensor fault monitor.
// assumes: comparator levels arrive asynchronously on pins; the
// serial clock is a second domain that stops outside frames.
`timescale 1ns/1ps
`include "hfm_defs.svh"
module hfm_fault_monitor
  import hfm_pkg::*;
#(
  parameter int FILT_REF = `HFM_FILT_REF,
  parameter int FILT_SNS = `HFM_FILT_SNS,
  parameter int FILT_HGND = `HFM_FILT_HGND,
  parameter int FILT_BATT0 = `HFM_FILT_BATT0,
  parameter int FILT_BATT1 = `HFM_FILT_BATT1,
  parameter int FILT_BATT2 = `HFM_FILT_BATT2,
  parameter int FILT_BATT3 = `HFM_FILT_BATT3,
  parameter int OC_SETTLE = `HFM_OC_SETTLE_CYC
) (
  // clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_spi_clk,
  input wire logic i_rstn,
  // serial pins
  input wire logic i_csn,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // comparators and heater pins
  input wire logic i_ref_cell_pin_low,
  input wire logic i_sense_pin_in_window,
  input wire logic i_heater_gate_sensed_on,
  input wire logic i_drain_above_batt_lo,
  input wire logic i_drain_above_batt_hi,
  input wire logic i_drain_below_gnd,
  input wire logic i_drain_above_open,
  input wire logic i_imp_test_on,
  input wire logic i_heater_pwm_input,
  output logic o_heater_gate_out,
  output logic o_drain_sink_en,
  output logic o_drain_source_en,
  // state views
  output logic [63:0] o_input_reg,
  output logic [`HFM_NFLAG-1:0] o_fault_flags
);
  // -----------------------------------------------------------------
  // synchronised input positions
  // -----------------------------------------------------------------
  localparam int IREF = 0;
  localparam int ISNS = 1;
  localparam int IGON = 2;
  localparam int IBLO = 3;
  localparam int IBHI = 4;
  localparam int IGND = 5;
  localparam int IOPN = 6;
  localparam int IIMP = 7;
  localparam int IPWM = 8;
  localparam int ICSN = 9;

  hfm_sys_s st;
  hfm_sys_s next_st;
  logic [9:0] in_raw;
  logic [63:0] rx_word;
  logic [`HFM_LEN_W-1:0] bit_cnt;
  logic ge64;
  logic frame_seen;
  logic [3:0] cond;
  logic [3:0] hit;
  logic [3:0][`HFM_CW-1:0] lim;
  logic frame_end;
  logic len_bad;
  logic cb_bad;
  logic inv_cmd;
  logic frame_bad;
  logic clr_now;

  assign in_raw = {i_csn, i_heater_pwm_input, i_imp_test_on,
    i_drain_above_open, i_drain_below_gnd, i_drain_above_batt_hi,
    i_drain_above_batt_lo, i_heater_gate_sensed_on,
    i_sense_pin_in_window, i_ref_cell_pin_low};

  // -----------------------------------------------------------------
  // serial link
  // -----------------------------------------------------------------
  hfm_spi_link u_link (
    .i_spi_clk(i_spi_clk),
    .i_rstn(i_rstn),
    .i_csn(i_csn),
    .i_si(i_si),
    .o_so(o_so),
    .i_status_word(st.status),
    .o_rx_word(rx_word),
    .o_bit_cnt(bit_cnt),
    .o_ge64(ge64),
    .o_frame_seen(frame_seen)
  );

  // -----------------------------------------------------------------
  // frame checks
  // -----------------------------------------------------------------
  // link words are static once chip select is high again; a frame with
  // no clock edge leaves the toggle alone and is ignored
  assign frame_end = st.s2[ICSN] & ~st.csn_d &
    (st.frm_tog[1] != st.frm_tog[2]);
  assign len_bad = ~ge64 | (bit_cnt[2:0] != 3'h0);
  assign cb_bad = rx_word[`HFM_B_CBLO] | ~rx_word[`HFM_B_CBHI];
  assign inv_cmd = (rx_word[`HFM_B_PUMPEN] &
      (rx_word[`HFM_B_REFPD] | rx_word[`HFM_B_PUMPPD])) |
    (st.cfg[`HFM_B_PUMPEN] &
      ((rx_word[`HFM_B_PCHAN] != st.cfg[`HFM_B_PCHAN]) |
       (rx_word[`HFM_B_COMP] != st.cfg[`HFM_B_COMP]) |
       (rx_word[`HFM_B_CAP_HI:`HFM_B_CAP_LO] !=
        st.cfg[`HFM_B_CAP_HI:`HFM_B_CAP_LO]))) |
    (st.cfg[`HFM_B_PUMPEN] & st.cfg[`HFM_B_CLAMPEN] &
      ((rx_word[`HFM_B_CLAMPLV] != st.cfg[`HFM_B_CLAMPLV]) |
       (rx_word[`HFM_B_CLAMP_SIM_SELECT] != st.cfg[`HFM_B_CLAMP_SIM_SELECT])));
  assign frame_bad = len_bad | cb_bad | inv_cmd;
  assign clr_now = st.cfg[`HFM_B_CLEAR];

  // -----------------------------------------------------------------
  // filter conditions and limits
  // -----------------------------------------------------------------
  always_comb begin
    cond[0] = st.cfg[`HFM_B_REFDIAG] & ~st.s2[IIMP] & st.s2[IREF];
    cond[1] = st.s2[ISNS];
    cond[2] = ~st.s2[IGON] & st.s2[IGND] & (st.oc == OC_IDLE);
    cond[3] = st.s2[IGON] &
      (st.cfg[`HFM_B_BATTTH] ? st.s2[IBHI] : st.s2[IBLO]);
    lim[0] = `HFM_CW'(FILT_REF);
    lim[1] = `HFM_CW'(FILT_SNS);
    lim[2] = `HFM_CW'(FILT_HGND);
    case (st.cfg[`HFM_B_FT_HI:`HFM_B_FT_LO])
      2'h0: lim[3] = `HFM_CW'(FILT_BATT0);
      2'h1: lim[3] = `HFM_CW'(FILT_BATT1);
      2'h2: lim[3] = `HFM_CW'(FILT_BATT2);
      default: lim[3] = `HFM_CW'(FILT_BATT3);
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    hit = 4'h0;
    next_st.s1 = in_raw;
    next_st.s2 = st.s1;
    next_st.csn_d = st.s2[ICSN];
    next_st.so_oe = ~st.s2[ICSN];
    // frame toggle from the serial clock, two flops before use
    next_st.frm_tog[1:0] = {st.frm_tog[0], frame_seen};
    for (int i = 0; i < 4; i++) begin
      if (!cond[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] != lim[i]) begin
        next_st.cnt[i] = st.cnt[i] + `HFM_CW'(1);
      end
      hit[i] = cond[i] & (st.cnt[i] == lim[i] - `HFM_CW'(1));
    end
    if (clr_now) begin
      next_st.flags = '0;
      next_st.flags[`HFM_F_SPIB] = 1'b1;
      next_st.gate_lock = 1'b0;
      next_st.oc = OC_IDLE;
      next_st.cfg[`HFM_B_CLEAR] = 1'b0;
    end
    // event sets below win over the clear above, except the open test result
    // ref flag
    if (hit[0]) begin
      next_st.flags[`HFM_F_REF] = 1'b1;
    end
    if (hit[1]) begin
      next_st.flags[`HFM_F_SNS] = 1'b1;
    end
    if (hit[3]) begin
      next_st.flags[`HFM_F_BATT] = 1'b1;
      next_st.gate_lock = 1'b1;
    end
    if (hit[2]) begin
      next_st.flags[`HFM_F_HGND] = 1'b1;
      next_st.gate_lock = 1'b1;
      next_st.oc = OC_SINK_OFF;
    end
    case (st.oc)
      OC_IDLE: begin
        next_st.oc_wait = '0;
      end
      OC_SINK_OFF: begin
        if (!clr_now) begin
          next_st.oc = OC_SRC_ON;
        end
      end
      OC_SRC_ON: begin
        next_st.oc_wait = st.oc_wait + `HFM_CW'(1);
        if (clr_now) begin
          next_st.oc = OC_IDLE;
        end else if (st.oc_wait >= `HFM_CW'(OC_SETTLE)) begin
          next_st.oc = OC_HOLD;
          if (st.s2[IOPN]) begin
            next_st.flags[`HFM_F_OPEN] = 1'b1;
            next_st.flags[`HFM_F_HGND] = 1'b0;
          end
        end
      end
      OC_HOLD: begin
        next_st.oc_wait = '0;
      end
      default: begin
        next_st.oc = OC_IDLE;
      end
    endcase
    next_st.sink = (next_st.oc == OC_IDLE);
    next_st.src = (next_st.oc == OC_SRC_ON) | (next_st.oc == OC_HOLD);
    next_st.gate = ~st.s2[IPWM] & ~next_st.gate_lock;
    if (frame_end) begin
      next_st.frm_tog[2] = st.frm_tog[1];
      if (frame_bad) begin
        next_st.flags[`HFM_F_SPIA] = 1'b1;
        next_st.flags[`HFM_F_SPIB] = 1'b0;
        next_st.cfg[`HFM_B_REG] = 1'b0;
      end else begin
        next_st.cfg = rx_word;
      end
    end
    if (st.s2[ICSN]) begin
      if (st.cfg[`HFM_B_REG]) begin
        next_st.status = st.cfg;
      end else begin
        next_st.status = {{(64 - `HFM_NFLAG){1'b0}}, st.flags};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
      st.s1 <= 10'h200;
      st.s2 <= 10'h200;
      st.csn_d <= 1'b1;
      st.cfg <= `HFM_CFG_RST;
      st.sink <= 1'b1;
      st.oc <= OC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_so_oe = st.so_oe;
  assign o_heater_gate_out = st.gate;
  assign o_drain_sink_en = st.sink;
  assign o_drain_source_en = st.src;
  assign o_input_reg = st.cfg;
  assign o_fault_flags = st.flags;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  ref_gate_a: assert property (
    $rose(st.flags[`HFM_F_REF]) |->
      $past(st.cfg[`HFM_B_REFDIAG]) && !$past(st.s2[IIMP]))
    else $error("ref flag set while check disabled");

  ref_filter_a: assert property (
    $rose(st.flags[`HFM_F_REF]) |->
      $past(st.cnt[0]) == `HFM_CW'(FILT_REF - 1))
    else $error("ref flag set before filter count");

  ref_latch_a: assert property (
    st.flags[`HFM_F_REF] && !clr_now |=> st.flags[`HFM_F_REF])
    else $error("ref flag dropped without clear");

  sns_filter_a: assert property (
    $rose(st.flags[`HFM_F_SNS]) |->
      $past(st.cnt[1]) == `HFM_CW'(FILT_SNS - 1) && $past(cond[1]))
    else $error("sense flag set before filter count");

  cnt_zero_a: assert property (
    !cond[1] |=> st.cnt[1] == '0)
    else $error("sense counter not cleared");

  batt_lock_a: assert property (
    $rose(st.flags[`HFM_F_BATT]) |-> !st.gate && st.gate_lock)
    else $error("gate not locked on battery short");

  oc_seq_a: assert property (
    $rose(st.flags[`HFM_F_HGND]) |-> !st.sink ##1 st.src && !st.sink)
    else $error("open test sequence wrong");

  oc_flag_a: assert property (
    $rose(st.flags[`HFM_F_OPEN]) |-> !st.flags[`HFM_F_HGND])
    else $error("ground flag kept with open flag");

  clear_a: assert property (
    clr_now && st.oc != OC_SINK_OFF |=>
      !st.cfg[`HFM_B_CLEAR] && st.sink && !st.src)
    else $error("clear did not restore defaults");

  frame_bad_a: assert property (
    frame_end && frame_bad |=> st.flags[`HFM_F_SPIA] &&
      !st.flags[`HFM_F_SPIB] && !st.cfg[`HFM_B_REG])
    else $error("bad frame not flagged");

  open_seen_c: cover property ($rose(st.flags[`HFM_F_OPEN]));
  batt_seen_c: cover property ($rose(st.flags[`HFM_F_BATT]));
  spi_fault_c: cover property (frame_end && frame_bad);
  clear_seen_c: cover property (clr_now ##1 !clr_now);
endmodule : hfm_fault_monitor

// ==== tb/hfm_spi_host.sv ====
// hfm_spi_host.sv: serial master standing in for the host controller.
// assumes: the bench calls xfer only between frames.
`timescale 1ns/1ps
module hfm_spi_host (
  // serial pins
  input wire logic i_so,
  output logic o_csn,
  output logic o_spi_clk,
  output logic o_si
);
  initial begin
    o_csn = 1'b1;
    o_spi_clk = 1'b0;
    o_si = 1'b0;
  end
  // ------------------------------------------------------------
  // frame transfer
  // ------------------------------------------------------------
  // frame sent as given
  task automatic xfer(input logic [127:0] w, input int n,
                      output logic [63:0] rd);
    rd = '0;
    o_csn = 1'b0;
    // status snapshot settles before the first edge
    #150;
    for (int e = 1; e <= n; e++) begin
      o_si = w[n-e];
      #3 o_spi_clk = 1'b1;
      #3 o_spi_clk = 1'b0;
      if (e <= 64) rd[64-e] = i_so;
    end
    #20 o_csn = 1'b1;
    // released line shows the inverse, never the last bit
    o_si = ~o_si;
  endtask : xfer
endmodule : hfm_spi_host

// ==== tb/hfm_fault_monitor_bench.sv ====
// hfm_fault_monitor_bench.sv: self-checking bench of the fault monitor.
// assumes: hfm_spi_host plays the master; filter counts shortened.
`timescale 1ns/1ps
module hfm_fault_monitor_bench;
  import hfm_pkg::*;
  localparam int FF = 3;
  localparam int OCS = 20;
  localparam int NB [4] = '{3, 4, 5, 6};
  localparam logic [63:0] KEEP = 64'h0e54_8000_0000_c000;
  localparam logic [63:0] CLR = 64'h0000_8000_0000_0000;
  logic clk = 1'b0;
  logic rstn = 1'b1;
  logic sclk, csn, si, so, so_oe, gate, sink, src;
  logic pwm = 1'b1;
  logic gon = 1'b0;
  logic [6:0] cond = '0;
  logic [63:0] cfg;
  logic [6:0] flg;
  logic [63:0] ecfg = '0;
  logic [6:0] eflg = '0;
  logic [31:0] seed = 32'h68bf2402;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  hfm_fault_monitor #(.FILT_REF(FF), .FILT_SNS(FF), .FILT_HGND(FF),
    .FILT_BATT0(NB[0]), .FILT_BATT1(NB[1]), .FILT_BATT2(NB[2]),
    .FILT_BATT3(NB[3]), .OC_SETTLE(OCS)) hfm_fault_monitor_i (
    .i_sys_clk(clk), .i_spi_clk(sclk), .i_rstn(rstn), .i_csn(csn),
    .i_si(si), .o_so(so), .o_so_oe(so_oe),
    .i_ref_cell_pin_low(cond[0]), .i_sense_pin_in_window(cond[1]),
    .i_heater_gate_sensed_on(gon), .i_drain_above_batt_lo(cond[2]),
    .i_drain_above_batt_hi(cond[3]), .i_drain_below_gnd(cond[4]),
    .i_drain_above_open(cond[5]), .i_imp_test_on(cond[6]),
    .i_heater_pwm_input(pwm), .o_heater_gate_out(gate),
    .o_drain_sink_en(sink), .o_drain_source_en(src),
    .o_input_reg(cfg), .o_fault_flags(flg));

  hfm_spi_host hfm_spi_host_i (.i_so(so), .o_csn(csn),
    .o_spi_clk(sclk), .o_si(si));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // random legal frame; risky control bits cleared
  function automatic logic [63:0] good();
    return ({xs(), xs()} & ~KEEP) | 64'h8000;
  endfunction : good

  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic done(input string t);
    $display("test %s finished, %0d checks", t, checks_done);
  endtask : done

  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // frame plus reference model of frame checking
  task automatic send(input logic [63:0] f, input int n = 64);
    logic [63:0] rd, eo;
    logic bad;
    eo = ecfg[59] ? ecfg : {57'h0, eflg};
    fork
      hfm_spi_host_i.xfer({good(), f}, n, rd);
      begin
        repeat (4) @(negedge clk);
        chk("so enable", 1, so_oe);
      end
    join
    repeat (8) @(negedge clk);
    chk("so enable", 0, so_oe);
    bad = n < 64 || n % 8 != 0 || f[15:14] != 2'b10
      || (f[54] && (f[58] || f[52]))
      || (ecfg[54] && (f[53] != ecfg[53] || f[51] != ecfg[51]
      || f[39:34] != ecfg[39:34]))
      || (ecfg[54] && ecfg[50] && f[49:48] != ecfg[49:48]);
    if (n >= 64) chk("out word", eo, rd);
    if (bad) begin
      eflg[6:5] = 2'b01;
      ecfg[59] = 1'b0;
    end else begin
      ecfg = f;
      if (f[47]) begin
        ecfg[47] = 1'b0;
        eflg = 7'h40;
      end
    end
    chk("input reg", ecfg, cfg);
    chk("flags", eflg, flg);
  endtask : send

  // comparator held for c cycles, then a settling tail
  task automatic pulse(input int b, input int c);
    cond[b] = 1'b1;
    repeat (c) @(negedge clk);
    cond[b] = 1'b0;
    repeat (6) @(negedge clk);
  endtask : pulse

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    // a real falling edge, so the stopped serial side resets too
    #1 rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    chk("sink", 1, sink);
    chk("source", 0, src);
    chk("flags", 0, flg);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      send(good() | (64'(i % 2) << 59));
    end
    send(good() ^ 64'h4000);
    send(good() ^ 64'h8000);
    send(good(), 70);
    send(good(), 56);
    send(good(), 72);
    done("frames");
    send(good() | 64'h0440_0000_0000_0000);
    send(good() | 64'h0050_0000_0000_0000);
    send(good() | 64'h0044_0000_0000_0000);
    send(ecfg ^ 64'h0020_0000_0000_0000);
    send(ecfg ^ 64'h0008_0000_0000_0000);
    send(ecfg ^ 64'h0000_0010_0000_0000);
    send(ecfg ^ 64'h0001_0000_0000_0000);
    send(ecfg & ~64'h0040_0000_0000_0000 | CLR);
    done("commands");
    send(good() | 64'h1 << 57);
    cond[6] = 1'b1;
    pulse(0, FF + 4);
    chk("flags", eflg, flg);
    cond[6] = 1'b0;
    pulse(0, FF - 1);
    chk("flags", eflg, flg);
    pulse(0, FF + 1);
    eflg[0] = 1'b1;
    chk("flags", eflg, flg);
    send(good());
    pulse(1, FF - 1);
    chk("flags", eflg, flg);
    pulse(1, FF + 1);
    eflg[1] = 1'b1;
    chk("flags", eflg, flg);
    send(ecfg | CLR);
    done("sensor");
    for (int s = 0; s < 4; s++) begin
      send(good() & ~64'h8000_1800 | 64'(s) << 11 | 64'(s % 2) << 31);
      pwm = 1'b0;
      gon = 1'b1;
      pulse(3 - s % 2, NB[s] + 4);
      pulse(2 + s % 2, NB[s] - 1);
      chk("flags", eflg, flg);
      chk("gate", 1, gate);
      pulse(2 + s % 2, NB[s] + 1);
      eflg[2] = 1'b1;
      pwm = 1'b1;
      repeat (3) @(negedge clk);
      pwm = 1'b0;
      repeat (3) @(negedge clk);
      chk("flags", eflg, flg);
      chk("gate", 0, gate);
      gon = 1'b0;
      send(ecfg | CLR);
      chk("gate", 1, gate);
    end
    pwm = 1'b1;
    cond[5] = 1'b1;
    pulse(4, FF - 1);
    chk("flags", eflg, flg);
    pulse(4, FF + 1);
    eflg[3] = 1'b1;
    chk("flags", eflg, flg);
    chk("gate", 0, gate);
    chk("sink", 0, sink);
    repeat (OCS + 6) @(negedge clk);
    eflg[4:3] = 2'b10;
    chk("flags", eflg, flg);
    chk("source", 1, src);
    cond[5] = 1'b0;
    send(ecfg | CLR);
    chk("sink", 1, sink);
    chk("source", 0, src);
    done("heater");
    close_out();
  end
endmodule : hfm_fault_monitor_bench
